// File: verilog/pcsl_pkg.sv
// Functional notes
// - Samples whose magnitude exceeds the channel threshold are clamped to that magnitude.
// - Channel 0 threshold bits 15:8 at 0x91, 7:0 at 0x92, read-write, reset 0xFF.
// - Channel 1 threshold 22:16 in 0x93 low bits, 15:8 0x94, 7:0 0x95, reset zero.
// - Channel 2 threshold 22:16 in 0x96 low bits, 15:8 0x97, 7:0 0x98, reset zero.
// - Channel 3 threshold 22:16 in 0x99 low bits, 15:8 0x9A, 7:0 0x9B, reset zero.
// - Channels 1 to 3 threshold also depends on the shared select bit 7 of 0x90.
//
// Package of constants and carriers for the four-channel sample limiter.
// Assumes a 200 MHz core clock and 24-bit two's complement samples.
package pcsl_pkg;

   localparam int unsigned CH_NUM  = 4;
   localparam int unsigned THR_W   = 23;
   localparam int unsigned SMP_W   = 24;
   localparam int unsigned ADDR_W  = 10;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned LVL_NUM = 12;
   localparam int unsigned SEL_BIT = 7;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CH0_HIGH = 8'h90;
   localparam logic [7:0] IDX_CH0_MID  = 8'h91;
   localparam logic [7:0] IDX_CH0_LOW  = 8'h92;
   localparam logic [7:0] IDX_CH1_HIGH = 8'h93;
   localparam logic [7:0] IDX_CH1_MID  = 8'h94;
   localparam logic [7:0] IDX_CH1_LOW  = 8'h95;
   localparam logic [7:0] IDX_CH2_HIGH = 8'h96;
   localparam logic [7:0] IDX_CH2_MID  = 8'h97;
   localparam logic [7:0] IDX_CH2_LOW  = 8'h98;
   localparam logic [7:0] IDX_CH3_HIGH = 8'h99;
   localparam logic [7:0] IDX_CH3_MID  = 8'h9A;
   localparam logic [7:0] IDX_CH3_LOW  = 8'h9B;
   localparam logic [7:0] IDX_CLIP     = 8'h9C;

   localparam logic [7:0] RST_CH0      = 8'hFF;
   localparam logic [7:0] RST_CHN      = 8'h00;
   localparam logic [7:0] MASK_HIGH    = 8'h7F;
   localparam logic [7:0] MASK_FULL    = 8'hFF;

   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_DECERR  = 2'h3;

   typedef struct packed {
      logic [CH_NUM-1:0][SMP_W-1:0] smp;
   } pcsl_frame_t;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [3:0]        byteenable;
      logic [DATA_W-1:0] writedata;
   } pcsl_av_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic [1:0]        response;
      logic              waitrequest;
   } pcsl_av_rsp_t;

endpackage

// File: verilog/pcsl_clamp.sv
// One channel of magnitude clamping, purely combinational.
// Assumes the threshold is an unsigned magnitude one bit narrower than the sample.
`timescale 1ns/1ps
module pcsl_clamp #(
   parameter int unsigned SMP_W = 24,
   parameter int unsigned THR_W = 23
) (
   input  wire logic [SMP_W-1:0] smp_in,
   input  wire logic [THR_W-1:0] thr,
   output logic      [SMP_W-1:0] smp_out,
   output logic                  clipped
);

   // Widened by one bit so that the magnitude of the most negative code fits
   wire logic signed [SMP_W:0] s_ext;
   wire logic signed [SMP_W:0] t_pos;
   wire logic signed [SMP_W:0] t_neg;
   wire logic                  over;
   wire logic                  under;

   assign s_ext   = {smp_in[SMP_W-1], smp_in};
   assign t_pos   = {2'h0, thr};
   assign t_neg   = -t_pos;
   assign over    = s_ext > t_pos;
   assign under   = s_ext < t_neg;
   assign clipped = over | under;
   assign smp_out = over  ? t_pos[SMP_W-1:0] :
                    under ? t_neg[SMP_W-1:0] : smp_in;

endmodule // pcsl_clamp

// File: verilog/pcsl_limiter.sv
// Four-channel sample limiter with Avalon-MM register slave.
// Samples enter as one frame of four channels with valid/ready
// and leave one cycle later from a single output register.
// Assumes the bus master holds a request until waitrequest is low.
`timescale 1ns/1ps
module pcsl_limiter (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire pcsl_pkg::pcsl_av_req_t av_req,
   output pcsl_pkg::pcsl_av_rsp_t    av_rsp,
   input  wire logic                 in_valid,
   output logic                      in_ready,
   input  wire pcsl_pkg::pcsl_frame_t in_frame,
   output logic                      out_valid,
   input  wire logic                 out_ready,
   output pcsl_pkg::pcsl_frame_t     out_frame,
   output logic [3:0]                out_clip
);

   localparam int unsigned NCH = pcsl_pkg::CH_NUM;
   localparam int unsigned TW  = pcsl_pkg::THR_W;
   localparam int unsigned SW  = pcsl_pkg::SMP_W;

   // ---------------- Bus decode ----------------
   logic                  ack;
   logic [31:0]           rdata;
   logic                  rd_err;
   logic [7:0]            lvl [pcsl_pkg::LVL_NUM];
   logic [NCH-1:0]        clip_flag;

   wire logic             req;
   wire logic [7:0]       word;
   wire logic             aligned;
   wire logic             lvl_hit;
   wire logic             clip_hit;
   wire logic             any_hit;
   wire logic [7:0]       off;
   wire logic [3:0]       lvl_idx;
   wire logic             wr_fire;
   wire logic             rd_take;
   wire logic [7:0]       lvl_rd;
   wire logic [31:0]      next_rdata;

   assign req      = av_req.read | av_req.write;
   assign word     = av_req.address[9:2];
   assign aligned  = av_req.address[1:0] == 2'h0;
   assign lvl_hit  = aligned &&
                     word >= pcsl_pkg::IDX_CH0_HIGH &&
                     word <= pcsl_pkg::IDX_CH3_LOW;
   assign clip_hit = aligned && word == pcsl_pkg::IDX_CLIP;
   assign any_hit  = lvl_hit | clip_hit;
   assign off      = word - pcsl_pkg::IDX_CH0_HIGH;
   assign lvl_idx  = off[3:0];

   // One wait cycle: the request is answered on the second edge
   assign wr_fire  = av_req.write & ack;
   assign rd_take  = av_req.read & ~ack;

   assign lvl_rd     = lvl_hit ? lvl[lvl_idx] : 8'h00;
   assign next_rdata = clip_hit ? {28'h0000000, clip_flag} :
                                  {24'h000000, lvl_rd};

   assign av_rsp.waitrequest = req & ~ack;
   assign av_rsp.readdata    = rdata;
   assign av_rsp.response    = rd_err ? pcsl_pkg::RESP_DECERR
                                      : pcsl_pkg::RESP_OKAY;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // Read data is captured one edge early so it stands during the answer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata  <= 32'h00000000;
         rd_err <= 1'b0;
      end else if (rd_take | (av_req.write & ~ack)) begin
         rdata  <= av_req.read ? next_rdata : 32'h00000000;
         rd_err <= ~any_hit;
      end
   end

   // ---------------- Threshold storage ----------------
   // Byte lane 0 only; other lanes carry nothing and are ignored
   wire logic lane0_wr;
   assign lane0_wr = wr_fire & lvl_hit & av_req.byteenable[0];

   genvar gi;
   generate
      for (gi = 0; gi < pcsl_pkg::LVL_NUM; gi++) begin : g_lvl
         // Channel 0 resets to all ones, the others to zero
         localparam logic [7:0] RST_V =
            (gi < 3) ? pcsl_pkg::RST_CH0 : pcsl_pkg::RST_CHN;
         // Bit 7 of the high bytes of channels 1-3 is reserved
         localparam logic [7:0] WMASK =
            (gi % 3 == 0 && gi != 0) ? pcsl_pkg::MASK_HIGH
                                     : pcsl_pkg::MASK_FULL;
         wire logic sel;
         assign sel = lane0_wr && lvl_idx == 4'(gi);
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               lvl[gi] <= RST_V;
            end else if (sel) begin
               lvl[gi] <= av_req.writedata[7:0] & WMASK;
            end
         end
      end
   endgenerate

   // ---------------- Threshold selection ----------------
   logic [TW-1:0]  own_thr [NCH];
   logic [TW-1:0]  eff_thr [NCH];
   wire logic      shared_threshold_select;

   assign shared_threshold_select = lvl[0][pcsl_pkg::SEL_BIT];

   generate
      for (gi = 0; gi < NCH; gi++) begin : g_thr
         assign own_thr[gi] = {lvl[3*gi][6:0],
                               lvl[3*gi+1],
                               lvl[3*gi+2]};
         // Shared mode points every channel at channel 0
         assign eff_thr[gi] = shared_threshold_select ? own_thr[0]
                                                      : own_thr[gi];
      end
   endgenerate

   wire logic [TW-1:0] clamp_threshold_ch0;
   wire logic [TW-1:0] clamp_threshold_ch1;
   wire logic [TW-1:0] clamp_threshold_ch2;
   wire logic [TW-1:0] clamp_threshold_ch3;
   assign clamp_threshold_ch0 = eff_thr[0];
   assign clamp_threshold_ch1 = eff_thr[1];
   assign clamp_threshold_ch2 = eff_thr[2];
   assign clamp_threshold_ch3 = eff_thr[3];

   // ---------------- Sample path ----------------
   pcsl_pkg::pcsl_frame_t clamped;
   logic [NCH-1:0]        clip_now;
   wire logic             in_fire;
   wire logic             out_fire;

   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         pcsl_clamp #(
            .SMP_W (SW),
            .THR_W (TW)
         ) u_clamp (
            .smp_in  (in_frame.smp[gi]),
            .thr     (eff_thr[gi]),
            .smp_out (clamped.smp[gi]),
            .clipped (clip_now[gi])
         );
      end
   endgenerate

   // A stalled output holds its frame; the input then stalls too
   assign in_ready = ~out_valid | out_ready;
   assign in_fire  = in_valid & in_ready;
   assign out_fire = out_valid & out_ready;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
      end else if (in_ready) begin
         out_valid <= in_valid;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_frame <= '0;
         out_clip  <= 4'h0;
      end else if (in_fire) begin
         out_frame <= clamped;
         out_clip  <= clip_now;
      end
   end

   // ---------------- Clip status ----------------
   // Write one to clear; a clip in the same cycle wins over the clear
   wire logic [NCH-1:0] clip_clr;
   wire logic [NCH-1:0] clip_set;
   wire logic [NCH-1:0] next_clip_flag;

   assign clip_clr = (wr_fire & clip_hit & av_req.byteenable[0])
                     ? av_req.writedata[NCH-1:0] : 4'h0;
   assign clip_set = out_fire ? out_clip : 4'h0;
   assign next_clip_flag = (clip_flag & ~clip_clr) | clip_set;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clip_flag <= 4'h0;
      end else begin
         clip_flag <= next_clip_flag;
      end
   end

   // ---------------- Checks ----------------
   wire logic signed [SW:0] s0;
   wire logic signed [SW:0] s1;
   wire logic signed [SW:0] t0;
   wire logic signed [SW:0] t1;
   assign s0 = {in_frame.smp[0][SW-1], in_frame.smp[0]};
   assign s1 = {in_frame.smp[1][SW-1], in_frame.smp[1]};
   assign t0 = {2'h0, eff_thr[0]};
   assign t1 = {2'h0, eff_thr[1]};

   // Signed copies so the shared-mode check compares magnitudes, not raw codes
   wire logic signed [SW:0] s3;
   wire logic signed [SW:0] t_sh;
   assign s3   = {in_frame.smp[3][SW-1], in_frame.smp[3]};
   assign t_sh = {2'h0, own_thr[0]};

   clamp_high_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      in_fire && s0 > t0
      |=> out_valid && out_frame.smp[0] == {1'b0, $past(eff_thr[0])}
          && out_clip[0])
      else $error("positive overshoot not clamped to threshold");

   clamp_low_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      in_fire && s1 < -t1
      |=> out_frame.smp[1] == SW'(-{2'h0, $past(eff_thr[1])}))
      else $error("negative overshoot not clamped to threshold");

   clamp_pass_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      in_fire && s0 <= t0 && s0 >= -t0
      |=> out_frame.smp[0] == $past(in_frame.smp[0]) && !out_clip[0])
      else $error("in-range sample altered");

   ch0_write_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && word == pcsl_pkg::IDX_CH0_MID && aligned
         && av_req.byteenable[0]
      |=> lvl[1] == $past(av_req.writedata[7:0])
          && own_thr[0][15:8] == $past(av_req.writedata[7:0]))
      else $error("channel 0 middle byte not written");

   ch1_reserved_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && aligned && word == pcsl_pkg::IDX_CH1_HIGH && av_req.byteenable[0]
      |=> lvl[3] == {1'b0, $past(av_req.writedata[6:0])}
          && own_thr[1][22:16] == $past(av_req.writedata[6:0]))
      else $error("channel 1 high byte or reserved bit wrong");

   ch2_readback_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      rd_take && aligned && word == pcsl_pkg::IDX_CH2_HIGH
      |=> av_rsp.readdata == {25'h0, $past(lvl[6][6:0])}
          && !av_rsp.waitrequest)
      else $error("channel 2 high byte readback wrong");

   ch3_low_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && aligned && word == pcsl_pkg::IDX_CH3_LOW && av_req.byteenable[0]
      |=> lvl[11] == $past(av_req.writedata[7:0])
          && own_thr[3][7:0] == $past(av_req.writedata[7:0]) && !lvl[9][7])
      else $error("channel 3 low byte not written");

   shared_on_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      shared_threshold_select
      |-> eff_thr[1] == own_thr[0] && eff_thr[2] == own_thr[0]
          && eff_thr[3] == own_thr[0])
      else $error("shared threshold not applied");

   shared_off_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      !shared_threshold_select
      |-> eff_thr[1] == own_thr[1] && eff_thr[2] == own_thr[2]
          && eff_thr[3] == own_thr[3])
      else $error("own threshold not applied");

   bus_answer_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      req && !ack |=> !av_rsp.waitrequest || !req)
      else $error("bus answer later than one wait cycle");

   clip_sticky_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      out_fire && out_clip[2] |=> clip_flag[2])
      else $error("clip flag lost");

   ch0_low_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && aligned && word == pcsl_pkg::IDX_CH0_LOW && av_req.byteenable[0]
      |=> own_thr[0][7:0] == $past(av_req.writedata[7:0]))
      else $error("channel 0 low byte not written");

   ch1_low_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && aligned && word == pcsl_pkg::IDX_CH1_LOW && av_req.byteenable[0]
      |=> own_thr[1][7:0] == $past(av_req.writedata[7:0]))
      else $error("channel 1 low byte not written");

   ch2_high_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && aligned && word == pcsl_pkg::IDX_CH2_HIGH && av_req.byteenable[0]
      |=> own_thr[2][22:16] == $past(av_req.writedata[6:0]) && !lvl[6][7])
      else $error("channel 2 high byte or reserved bit wrong");

   // Checked on the edge that first sees reset released, before any write
   reset_level_a: assert property (
      @(posedge clk)
      $rose(rst_b)
      |-> lvl[1] == pcsl_pkg::RST_CH0 && lvl[2] == pcsl_pkg::RST_CH0
          && lvl[4] == pcsl_pkg::RST_CHN && lvl[8] == pcsl_pkg::RST_CHN
          && lvl[10] == pcsl_pkg::RST_CHN)
      else $error("threshold byte reset value wrong");

   resp_okay_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      req && !ack && any_hit |=> av_rsp.response == pcsl_pkg::RESP_OKAY)
      else $error("mapped access answered with an error");

   resp_err_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      req && !ack && !any_hit
      |=> av_rsp.response == pcsl_pkg::RESP_DECERR && av_rsp.readdata == 32'h00000000)
      else $error("unmapped access not refused");

   // A stalled output neither takes a frame nor changes what it shows
   stall_hold_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      out_valid && !out_ready
      |-> !in_ready ##1 (out_valid && $stable(out_frame) && $stable(out_clip)))
      else $error("stalled output frame not held");

   frame_answer_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      in_fire |=> out_valid)
      else $error("accepted frame not offered next cycle");

   clip_clear_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && clip_hit && av_req.byteenable[0] && !out_fire
      |=> (clip_flag & $past(av_req.writedata[NCH-1:0])) == 4'h0)
      else $error("clip flag not cleared by write");

   // Writes to other lanes, to status or to holes must leave thresholds alone
   lvl_keep_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_fire && !lane0_wr
      |=> $stable(own_thr[0]) && $stable(own_thr[1]) && $stable(own_thr[2])
          && $stable(own_thr[3]) && $stable(shared_threshold_select))
      else $error("ignored write changed a threshold");

   shared_clamp_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      in_fire && shared_threshold_select && s3 > t_sh
      |=> out_frame.smp[3] == {1'b0, $past(own_thr[0])} && out_clip[3])
      else $error("shared threshold not used on channel 3");

endmodule // pcsl_limiter

// File: verification/pcsl_sink_model.sv
// Sink model standing for the following audio processing stage.
// Assumes the limiter offers frames with valid/ready on clk.
`timescale 1ns/1ps
module pcsl_sink_model (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic slow,
   output logic      out_ready
);
   // Slow mode stalls every other cycle so frames must wait at the output
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         out_ready <= 1'b0;
      else
         out_ready <= slow ? !out_ready : 1'b1;
   end
endmodule // pcsl_sink_model

// File: verification/tb_top.sv
// Self-checking bench for the four-channel sample limiter.
// Assumes the design package is compiled first; a sink model drains the output.
`timescale 1ns/1ps
module tb_top;
   logic                   clk;
   logic                   rst_b;
   logic                   slow;
   logic                   shared;
   pcsl_pkg::pcsl_av_req_t av_req;
   pcsl_pkg::pcsl_av_rsp_t av_rsp;
   logic                   in_valid;
   logic                   in_ready;
   pcsl_pkg::pcsl_frame_t  in_frame;
   logic                   out_valid;
   logic                   out_ready;
   pcsl_pkg::pcsl_frame_t  out_frame;
   logic [3:0]             out_clip;
   logic [22:0]            thr [4];
   int                     miscompares;
   int                     samples_checked;

   pcsl_limiter pcsl_limiter_inst (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
      .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame), .out_valid(out_valid),
      .out_ready(out_ready), .out_frame(out_frame), .out_clip(out_clip));
   pcsl_sink_model pcsl_sink_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .out_ready(out_ready));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Holds the request until waitrequest is sampled low, then takes the answer
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] rdata, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      av_req.read <= !wr;
      av_req.write <= wr;
      av_req.address <= {idx, 2'b00};
      av_req.writedata <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (av_rsp.waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         miscompares++;
         print_verdict();
      end
      rdata = av_rsp.readdata;
      resp = av_rsp.response;
      av_req.read <= 1'b0;
      av_req.write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic [1:0]  s;
      bus(1'b1, idx, d, r, s);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] s);
      logic [31:0] r;
      logic [1:0]  rs;
      bus(1'b0, idx, 8'h00, r, rs);
      check({64'h0, r}, {64'h0, 24'h0, d}, "readdata");
      check({94'h0, rs}, {94'h0, s}, "response");
   endtask

   // Expected result worked out with signed magnitude compare per channel
   task automatic send(input logic [95:0] f);
      pcsl_pkg::pcsl_frame_t exp;
      logic [3:0]            clip;
      logic signed [24:0]    s;
      logic signed [24:0]    t;
      logic signed [24:0]    neg;
      int                    n;
      for (int c = 0; c < 4; c++) begin
         t = {2'b00, (shared ? thr[0] : thr[c])};
         neg = -t;
         s = {f[c*24+23], f[c*24 +: 24]};
         clip[c] = (s > t) || (s < neg);
         exp.smp[c] = (s > t) ? t[23:0] : ((s < neg) ? neg[23:0] : s[23:0]);
      end
      n = 0;
      @(posedge clk);
      in_valid <= 1'b1;
      in_frame <= pcsl_pkg::pcsl_frame_t'(f);
      do begin
         @(posedge clk);
         n++;
      end while (in_ready !== 1'b1 && n < 50);
      in_valid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (!(out_valid === 1'b1 && out_ready === 1'b1) && n < 50);
      if (n >= 50) begin
         miscompares++;
         print_verdict();
      end
      check(out_frame, exp, "frame");
      check({92'h0, out_clip}, {92'h0, clip}, "clip");
   endtask

   task automatic test_reset();
      for (int i = 8'h90; i <= 8'h9B; i++)
         rd(8'(i), (i <= 8'h92) ? 8'hFF : 8'h00, pcsl_pkg::RESP_OKAY);
   endtask

   task automatic test_regs();
      wr(8'h90, 8'h00);
      wr(8'h91, 8'h12);
      wr(8'h92, 8'h34);
      wr(8'h93, 8'hFF);
      wr(8'h95, 8'h01);
      wr(8'h96, 8'h80);
      wr(8'h99, 8'h01);
      wr(8'h9B, 8'h5A);
      thr = '{23'h001234, 23'h7F0001, 23'h000000, 23'h01005A};
      rd(8'h91, 8'h12, pcsl_pkg::RESP_OKAY);
      rd(8'h92, 8'h34, pcsl_pkg::RESP_OKAY);
      rd(8'h93, 8'h7F, pcsl_pkg::RESP_OKAY);
      rd(8'h95, 8'h01, pcsl_pkg::RESP_OKAY);
      rd(8'h96, 8'h00, pcsl_pkg::RESP_OKAY);
      rd(8'h99, 8'h01, pcsl_pkg::RESP_OKAY);
      rd(8'h9B, 8'h5A, pcsl_pkg::RESP_OKAY);
      // Lane 0 disabled: the write must be ignored
      av_req.byteenable <= 4'hE;
      wr(8'h94, 8'hAA);
      av_req.byteenable <= 4'hF;
      rd(8'h94, 8'h00, pcsl_pkg::RESP_OKAY);
      rd(8'h9D, 8'h00, pcsl_pkg::RESP_DECERR);
   endtask

   // Own thresholds: above, below, exact and the most negative sample
   task automatic test_own();
      send({24'h01005B, 24'h000001, 24'h800000, 24'h001235});
      send({24'hFEFFA6, 24'h000000, 24'h7FFFFF, 24'hFFEDCC});
      // Status: all four clipped above; clear channels 0 and 2 only
      rd(8'h9C, 8'h0F, pcsl_pkg::RESP_OKAY);
      wr(8'h9C, 8'h05);
      rd(8'h9C, 8'h0A, pcsl_pkg::RESP_OKAY);
   endtask

   // Shared select with a stalling sink so the output must hold
   task automatic test_shared();
      wr(8'h90, 8'h80);
      shared = 1'b1;
      slow <= 1'b1;
      send({24'hFFEDCB, 24'h001233, 24'h800001, 24'h7FFFFF});
      send({24'h001235, 24'hFFEDCC, 24'h000000, 24'h001234});
      rd(8'h90, 8'h80, pcsl_pkg::RESP_OKAY);
   endtask

   initial begin
      rst_b = 1'b0;
      slow = 1'b0;
      shared = 1'b0;
      in_valid = 1'b0;
      in_frame = '0;
      av_req = pcsl_pkg::pcsl_av_req_t'{read: 1'b0, write: 1'b0, address: '0, byteenable: 4'hF, writedata: '0};
      thr = '{default: '0};
      miscompares = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      test_reset();
      test_regs();
      test_own();
      test_shared();
      print_verdict();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #50000;
      miscompares++;
      print_verdict();
   end
endmodule // tb_top
